// file: rtl/ldec_device.sv
// driver end: decodes line pulses into enable, level and shutdown, and picks pump mode from the regulation monitor
`timescale 1ns/10ps
`default_nettype none
module ldec_device
	import ldec_pkg::*;
#(
	parameter int SHUTDOWN_CYC = SHUTDOWN_LOW_CYC,
	parameter int PUMP_CYC     = PUMP_DELAY_CYC
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	ldec_link_if.dev_end       link,
	input  wire logic          supply_low_lockout,
	input  wire logic          regulation_ok,
	output logic               enabled,
	output logic [LEVEL_W-1:0] level,
	output logic [CUR_W-1:0]   led_sink_a,
	output logic [CUR_W-1:0]   led_sink_b,
	output logic               led_sink_a_oe_b,
	output logic               led_sink_b_oe_b,
	output logic               pump_boost
);
	// =====================================================
	// synchronisers: line, supply lockout, regulation monitor
	localparam int                SYNC_N   = 3;
	localparam logic [SYNC_N-1:0] SYNC_RST = 3'b100; // regulation counts as met until seen
	logic [SYNC_N-1:0] async_in;
	logic              sync_out [SYNC_N];
	logic              line_s2;
	logic              line_d;
	logic              uv_s2;
	logic              reg_s2;
	assign async_in = {regulation_ok, supply_low_lockout, link.enable_dim_line};
	genvar gs;
	generate
		for (gs = 0; gs < SYNC_N; gs++) begin : g_sync
			logic s1;
			logic s2;
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					s1 <= SYNC_RST[gs];
					s2 <= SYNC_RST[gs];
				end else begin
					s1 <= async_in[gs];
					s2 <= s1;
				end
			end
			assign sync_out[gs] = s2;
		end
	endgenerate
	assign line_s2 = sync_out[0];
	assign uv_s2   = sync_out[1];
	assign reg_s2  = sync_out[2];
	// =====================================================
	// edge detector, reset to the idle low level of the line
	logic rise;
	logic fall;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			line_d <= 1'b0;
		end else begin
			line_d <= line_s2;
		end
	end
	assign rise = line_s2 & ~line_d;
	assign fall = ~line_s2 & line_d;
	// =====================================================
	// shutdown timer: synced low cycles while enabled
	localparam int LOW_W = $clog2(SHUTDOWN_CYC + 1);
	logic [LOW_W-1:0] low_cnt;
	logic [LOW_W-1:0] next_low_cnt;
	logic             low_expire;
	always_comb begin
		next_low_cnt = low_cnt;
		// the count parks at its end so a very long low never wraps
		if (line_s2) begin
			next_low_cnt = '0;
		end else if (enabled && low_cnt != LOW_W'(SHUTDOWN_CYC)) begin
			next_low_cnt = low_cnt + 1'b1;
		end
	end
	assign low_expire = !line_s2 && (low_cnt == LOW_W'(SHUTDOWN_CYC - 1));
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt <= '0;
		end else begin
			low_cnt <= next_low_cnt;
		end
	end
	// =====================================================
	// enable and dimming level
	localparam logic [LEVEL_W-1:0] LEVEL_LAST = LEVEL_OFF - 6'h01; // zero-current table step
	logic               next_enabled;
	logic [LEVEL_W-1:0] next_level;
	always_comb begin
		next_enabled = enabled;
		next_level   = level;
		if (!enabled) begin
			if (rise) begin
				next_enabled = 1'b1;
				next_level   = LEVEL_OFF;
			end
		end else if (low_expire) begin
			next_enabled = 1'b0;
			next_level   = LEVEL_OFF;
		end else if (fall) begin
			// both zero-current levels wrap straight back to full scale
			if (level >= LEVEL_LAST) begin
				next_level = LEVEL_FULL;
			end else begin
				next_level = level + 1'b1;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			enabled <= 1'b0;
			level   <= LEVEL_OFF;
		end else begin
			enabled <= next_enabled;
			level   <= next_level;
		end
	end
	// =====================================================
	// sink outputs, one slice per channel
	localparam int    CHAN_N = 2;
	logic [CUR_W-1:0] next_cur;
	logic             sink_off;
	logic [CUR_W-1:0] sink_cur [CHAN_N];
	logic             sink_oe_b [CHAN_N];
	always_comb begin
		sink_off = !enabled || uv_s2;
		next_cur = ldec_current(level);
		if (sink_off) begin
			next_cur = '0;
		end
	end
	// both channels share one level, so they always match
	genvar gc;
	generate
		for (gc = 0; gc < CHAN_N; gc++) begin : g_chan
			logic [CUR_W-1:0] cur;
			logic             oe_b;
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					cur  <= '0;
					oe_b <= 1'b1;
				end else begin
					cur  <= next_cur;
					oe_b <= sink_off;
				end
			end
			assign sink_cur[gc]  = cur;
			assign sink_oe_b[gc] = oe_b;
		end
	endgenerate
	assign led_sink_a      = sink_cur[0];
	assign led_sink_b      = sink_cur[1];
	assign led_sink_a_oe_b = sink_oe_b[0];
	assign led_sink_b_oe_b = sink_oe_b[1];
	// =====================================================
	// pump mode selection
	localparam int PMP_W = $clog2(PUMP_CYC + 1);
	logic [PMP_W-1:0] pmp_cnt, next_pmp_cnt;
	logic             next_pump_boost;
	always_comb begin
		next_pump_boost = pump_boost;
		next_pmp_cnt    = pmp_cnt;
		if (!enabled) begin
			next_pump_boost = 1'b0;
			next_pmp_cnt    = '0;
		end else if (!pump_boost) begin
			if (reg_s2) begin
				next_pmp_cnt = '0;
			end else if (pmp_cnt == PMP_W'(PUMP_CYC - 1)) begin
				next_pump_boost = 1'b1;
			end else begin
				next_pmp_cnt = pmp_cnt + 1'b1;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pump_boost <= 1'b0;
			pmp_cnt    <= '0;
		end else begin
			pump_boost <= next_pump_boost;
			pmp_cnt    <= next_pmp_cnt;
		end
	end
endmodule // ldec_device
`default_nettype wire

// file: rtl/ldec_pkg.sv
// shared constants for the led dimming single-wire link
package ldec_pkg;
	// =====================================================
	// clock
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_NS = 25;
	// =====================================================
	// link timing, each figure in its own unit then in cycles
	localparam int WAKE_SETUP_TIME_NS = 10_000;
	localparam int PROGRAM_LOW_MIN_NS = 300;
	localparam int PROGRAM_LOW_MAX_NS = 200_000;
	localparam int PROGRAM_HIGH_TIME_NS = 300;
	localparam int SHUTDOWN_LOW_US10 = 15; // 1.5 ms in units of 100 us
	localparam int PUMP_DELAY_US = 400;
	localparam int PULSE_RATE_MAX_HZ = 1_000_000;
	localparam int WAKE_SETUP_CYC = (WAKE_SETUP_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROGRAM_LOW_MIN_CYC = (PROGRAM_LOW_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROGRAM_LOW_MAX_CYC = PROGRAM_LOW_MAX_NS / CLK_NS;
	localparam int PROGRAM_HIGH_CYC = (PROGRAM_HIGH_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int SHUTDOWN_LOW_CYC = SHUTDOWN_LOW_US10 * (CLK_HZ / 10_000);
	localparam int PUMP_DELAY_CYC = PUMP_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int PULSE_PERIOD_MIN_CYC = CLK_HZ / PULSE_RATE_MAX_HZ;
	// =====================================================
	// dimming level: index 0 is full scale, 32 steps, 32 means zero current
	localparam int LEVEL_W = 6;
	localparam logic [5:0] LEVEL_OFF = 6'h20;
	localparam logic [5:0] LEVEL_FULL = 6'h00;
	localparam int CUR_W = 11; // current in units of 0.1 mA
	// =====================================================
	// current table, tenths of a mA, for pulse counts 1..32
	function automatic logic [10:0] ldec_current(input logic [5:0] idx);
		logic [10:0] tab [0:32];
		tab = '{11'h5DC, 11'h5AA, 11'h578, 11'h54B, 11'h51E, 11'h4EC, 11'h4BA,
			11'h488, 11'h456, 11'h429, 11'h3F7, 11'h3CA, 11'h398, 11'h366,
			11'h334, 11'h307, 11'h2D5, 11'h2A8, 11'h276, 11'h244, 11'h212,
			11'h1E5, 11'h1B3, 11'h186, 11'h154, 11'h122, 11'h0F0, 11'h0BE,
			11'h091, 11'h064, 11'h032, 11'h000, 11'h000};
		return tab[idx];
	endfunction
endpackage

// file: rtl/ldec_link_if.sv
// single-wire enable and dimming line between host and driver
`timescale 1ns/10ps
`default_nettype none
interface ldec_link_if;
	logic enable_dim_line;
	modport host_end (output enable_dim_line);
	modport dev_end (input enable_dim_line);
endinterface
`default_nettype wire

// file: rtl/ldec_host.sv
// host end: turns requests into timed pulses on the dimming line
`timescale 1ns/10ps
`default_nettype none
module ldec_host
	import ldec_pkg::*;
#(
	parameter int SETUP_CYC = WAKE_SETUP_CYC,
	parameter int LOW_CYC   = PROGRAM_LOW_MIN_CYC,
	parameter int HIGH_CYC  = PROGRAM_HIGH_CYC,
	parameter int OFF_CYC   = SHUTDOWN_LOW_CYC
) (
	input  wire logic    clk,
	input  wire logic    rst_b,
	ldec_link_if.host_end link,
	input  wire logic    wake_req,
	input  wire logic    pulse_req,
	input  wire logic    off_req,
	output logic         ready,
	output logic         awake
);
	typedef enum logic [2:0] {ST_OFF, ST_SETUP, ST_IDLE, ST_LOW, ST_HIGH, ST_DOWN}
		ldec_hstate_type;
	// high time stretched so that one low plus one high never beats the fastest pulse rate
	localparam int GAP_CYC = (PULSE_PERIOD_MIN_CYC - LOW_CYC > HIGH_CYC) ?
		PULSE_PERIOD_MIN_CYC - LOW_CYC : HIGH_CYC;
	localparam int CW = $clog2(OFF_CYC + SETUP_CYC + GAP_CYC + 2);
	ldec_hstate_type state, next_state;
	logic [CW-1:0]   cnt, next_cnt;
	logic            line, next_line;
	always_comb begin
		next_state = state;
		next_cnt   = cnt + 1'b1;
		next_line  = line;
		case (state)
			ST_OFF: begin
				next_cnt = '0;
				if (wake_req) begin
					next_state = ST_SETUP;
					next_line  = 1'b1;
				end
			end
			ST_SETUP: begin
				if (cnt == CW'(SETUP_CYC - 1)) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				next_cnt = '0;
				if (off_req) begin
					next_state = ST_DOWN;
					next_line  = 1'b0;
				end else if (pulse_req) begin
					next_state = ST_LOW;
					next_line  = 1'b0;
				end
			end
			ST_LOW: begin
				if (cnt == CW'(LOW_CYC - 1)) begin
					next_state = ST_HIGH;
					next_line  = 1'b1;
					next_cnt   = '0;
				end
			end
			ST_HIGH: begin
				if (cnt == CW'(GAP_CYC - 1)) begin
					next_state = ST_IDLE;
				end
			end
			ST_DOWN: begin
				if (cnt == CW'(OFF_CYC + 1)) begin
					next_state = ST_OFF;
				end
			end
			default: begin
				next_state = ST_OFF;
				next_line  = 1'b0;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_OFF;
			cnt   <= '0;
			line  <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			line  <= next_line;
		end
	end
	assign link.enable_dim_line = line;
	assign ready = (state == ST_OFF) || (state == ST_IDLE);
	assign awake = (state == ST_IDLE);
endmodule // ldec_host
`default_nettype wire

// file: verif/ldec_props.sv
// assertions on the dimming line and the driver outputs
`timescale 1ns/10ps
`default_nettype none
module ldec_props
	import ldec_pkg::*;
#(
	parameter int SHUTDOWN_CYC = 50,
	parameter int PUMP_CYC     = 20
) (
	input wire logic             clk,
	input wire logic             rst_b,
	input wire logic             enable_dim_line,
	input wire logic             supply_low_lockout,
	input wire logic             regulation_ok,
	input wire logic             enabled,
	input wire logic [CUR_W-1:0] led_sink_a,
	input wire logic [CUR_W-1:0] led_sink_b,
	input wire logic             led_sink_a_oe_b,
	input wire logic             led_sink_b_oe_b,
	input wire logic             pump_boost
);
	// ==========================================
	// cycles of line low and of lost regulation
	int low_cnt, next_low_cnt, bad_cnt, next_bad_cnt;
	always_comb begin
		next_low_cnt = enable_dim_line ? 0 : low_cnt + 1;
		next_bad_cnt = (regulation_ok || !enabled) ? 0 : bad_cnt + 1;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt <= 0;
			bad_cnt <= 0;
		end else begin
			low_cnt <= next_low_cnt;
			bad_cnt <= next_bad_cnt;
		end
	end
	// ==========================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_wake_enable: assert property (!enabled && $rose(enable_dim_line) |-> ##[1:4] enabled)
		else $error("no enable after line rise");
	chk_wake_zero: assert property ($rose(enabled) |-> led_sink_a == 0)
		else $error("current not zero at enable");
	chk_sinks_equal: assert property (led_sink_a == led_sink_b)
		else $error("channels differ");
	chk_wrap_full: assert property (enabled && !supply_low_lockout && led_sink_a == 0
		&& $fell(enable_dim_line) |-> ##[1:6] led_sink_a == 11'h5DC)
		else $error("no full scale after fall at zero");
	chk_long_low_off: assert property (low_cnt == SHUTDOWN_CYC + 4 |-> !enabled)
		else $error("no shutdown after long low");
	chk_no_early_off: assert property ($fell(enabled) |-> low_cnt >= SHUTDOWN_CYC)
		else $error("shutdown too early");
	chk_off_hiz: assert property (!enabled && $past(!enabled) |-> led_sink_a_oe_b
		&& led_sink_b_oe_b && led_sink_a == 0)
		else $error("sinks active in shutdown");
	chk_lockout_zero: assert property (supply_low_lockout [*4] |-> led_sink_b == 0)
		else $error("current during lockout");
	chk_pump_early: assert property ($rose(pump_boost) |-> bad_cnt >= PUMP_CYC)
		else $error("boost too early");
	chk_pump_late: assert property (bad_cnt == PUMP_CYC + 5 |-> pump_boost)
		else $error("boost too late");
	chk_wake_1x: assert property ($rose(enabled) |-> !pump_boost)
		else $error("boost kept over wake");
endmodule // ldec_props
`default_nettype wire

// file: verif/ldec_device_tb.sv
// testbench joining host and driver ends over the dimming line
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t %s", $time, m); end end
module ldec_device_tb;
	import ldec_pkg::*;
	logic              clk = 0, rst_b = 0, wake_req = 0, pulse_req = 0, off_req = 0;
	logic              supply_low_lockout = 0, regulation_ok = 1;
	logic              ready, awake, enabled, pump_boost, led_sink_a_oe_b, led_sink_b_oe_b;
	logic [LEVEL_W-1:0] level;
	logic [CUR_W-1:0]   led_sink_a, led_sink_b;
	localparam int      TB_SHUT_CYC = 50;
	localparam int      TB_PUMP_CYC = 20;
	logic [20:0]        exp_q[$];
	logic [20:0]        e;
	logic [20:0]        obs_a;
	int                 failures = 0, tests_run = 0, seed;
	int                 chk_p[7] = '{1, 2, 4, 10, 31, 32, 33};
	logic [10:0]        chk_v[7] = '{11'h5DC, 11'h5AA, 11'h54B, 11'h429, 11'h032, 11'h000, 11'h5DC};
	event               chk_ev;
	always #12.5 clk = ~clk;
	ldec_link_if ldec_link_if_inst ();
	ldec_host #(.OFF_CYC(TB_SHUT_CYC)) ldec_host_inst (.clk(clk), .rst_b(rst_b),
		.link(ldec_link_if_inst), .wake_req(wake_req), .pulse_req(pulse_req),
		.off_req(off_req), .ready(ready), .awake(awake));
	ldec_device #(.SHUTDOWN_CYC(TB_SHUT_CYC), .PUMP_CYC(TB_PUMP_CYC)) ldec_device_inst (
		.clk(clk), .rst_b(rst_b),
		.link(ldec_link_if_inst), .supply_low_lockout(supply_low_lockout),
		.regulation_ok(regulation_ok), .enabled(enabled), .level(level),
		.led_sink_a(led_sink_a), .led_sink_b(led_sink_b), .led_sink_a_oe_b(led_sink_a_oe_b),
		.led_sink_b_oe_b(led_sink_b_oe_b), .pump_boost(pump_boost));
	ldec_props #(.SHUTDOWN_CYC(TB_SHUT_CYC), .PUMP_CYC(TB_PUMP_CYC)) ldec_props_inst (
		.clk(clk), .rst_b(rst_b),
		.enable_dim_line(ldec_link_if_inst.enable_dim_line),
		.supply_low_lockout(supply_low_lockout), .regulation_ok(regulation_ok),
		.enabled(enabled), .led_sink_a(led_sink_a), .led_sink_b(led_sink_b),
		.led_sink_a_oe_b(led_sink_a_oe_b), .led_sink_b_oe_b(led_sink_b_oe_b),
		.pump_boost(pump_boost));
	// ==========================================
	// monitor: oldest note against the outputs
	assign obs_a = {level, awake, enabled, led_sink_a_oe_b, pump_boost, led_sink_a};
	always @(chk_ev) begin
		e = exp_q.pop_front();
		`CHK(obs_a, e, "level, state or current a")
		`CHK({led_sink_b_oe_b, led_sink_b}, {e[12], e[10:0]}, "sink b")
	end
	// level, host awake, {enabled, sink off, boost}, current
	task note(input logic [5:0] lv, input logic aw, input logic [2:0] f, input logic [10:0] c);
		exp_q.push_back({lv, aw, f, c});
		->chk_ev;
	endtask
	task finish_test();
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// 0 wake, 1 pulse, 2 off; waits for the host to be ready again
	task req(input int k);
		int n;
		case (k)
			0: wake_req = 1;
			1: pulse_req = 1;
			default: off_req = 1;
		endcase
		@(negedge clk);
		{wake_req, pulse_req, off_req} = 3'b000;
		n = 0;
		while (ready !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		if (n == 2000) begin
			failures++;
			finish_test();
		end
		repeat (4 + ($unsigned($random(seed)) % 4)) @(negedge clk);
	endtask
	// ==========================================
	// main sequence
	initial begin
		seed = 79255;
		repeat (5) @(negedge clk);
		rst_b = 1;
		note(LEVEL_OFF, 1'b0, 3'b010, 11'h000);
		req(0);
		note(LEVEL_OFF, 1'b1, 3'b100, 11'h000);
		$display("wake test done");
		for (int p = 1; p <= 34; p++) begin
			req(1);
			foreach (chk_p[i]) if (chk_p[i] == p)
				note(6'((p - 1) % 32), 1'b1, 3'b100, chk_v[i]);
		end
		$display("dimming test done");
		regulation_ok = 0;
		repeat (15) @(negedge clk);
		note(6'h01, 1'b1, 3'b100, 11'h5AA);
		repeat (15) @(negedge clk);
		note(6'h01, 1'b1, 3'b101, 11'h5AA);
		regulation_ok = 1;
		supply_low_lockout = 1;
		repeat (6) @(negedge clk);
		note(6'h01, 1'b1, 3'b111, 11'h000);
		supply_low_lockout = 0;
		repeat (6) @(negedge clk);
		note(6'h01, 1'b1, 3'b101, 11'h5AA);
		$display("pump and lockout test done");
		req(2);
		note(LEVEL_OFF, 1'b0, 3'b010, 11'h000);
		req(0);
		note(LEVEL_OFF, 1'b1, 3'b100, 11'h000);
		req(1);
		note(LEVEL_FULL, 1'b1, 3'b100, 11'h5DC);
		$display("shutdown test done");
		finish_test();
	end
endmodule // ldec_device_tb
`default_nettype wire
